// file: hw/vltc_top.sv
// line and transmit control register bank with axi4-lite slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - pulsed coding uses input 0, no diagnosis
// - manchester coding at reset, all three inputs
// - retry up to count, count plus one tries
// - lost contention retries forever, not an error
// - version field fixed, hardware writes it back
// - type one allows autonomous rank 0
// - type zero: rank 1 or 16 only
module vltc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line pins
  input wire logic line_input_0,
  input wire logic line_input_1,
  input wire logic line_input_2,
  output logic line_output,
  // protocol engine side
  input wire logic eng_tx_bit,
  output logic [2:0] eng_rx_bits,
  output logic [2:0] eng_rx_enable,
  output logic diag_enable,
  output logic [3:0] line_clock_divider,
  input wire logic tx_start,
  input wire logic tx_ok,
  input wire logic tx_error,
  input wire logic tx_contention,
  output logic tx_retry,
  output logic tx_abandon,
  input wire logic [4:0] req_rank,
  output logic rank_allowed
);
  // =====================================================================
  // register state
  logic [7:0] line_coding_q;
  logic [7:0] retry_ctl_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_held_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [4:0] attempts_q;

  // =====================================================================
  // setting fields
  wire pulsed_coding_select = line_coding_q[vltc_pkg::PULSED_BIT];
  wire invert_line_output = line_coding_q[vltc_pkg::INV_OUT_BIT];
  wire invert_line_inputs = line_coding_q[vltc_pkg::INV_IN_BIT];
  wire [3:0] max_retry_count = retry_ctl_q[vltc_pkg::RETRY_LSB +: 4];
  wire [2:0] version_code_field = retry_ctl_q[vltc_pkg::VERSION_LSB +: 3];
  wire module_type_select = retry_ctl_q[vltc_pkg::TYPE_BIT];
  // fixed version code, never taken from the bus
  wire [2:0] version_fixed = vltc_pkg::VERSION_CODE;
  assign line_clock_divider = line_coding_q[vltc_pkg::DIVIDER_LSB +: 4];

  // =====================================================================
  // write channel handshake: address and data taken in either order
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_held_q | aw_take;
  wire have_w = w_held_q | w_take;
  wire wr_go = have_aw & have_w & ~bvalid_q;
  wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire wr_line = wr_addr == vltc_pkg::LINE_CODING_ADDR;
  wire wr_retry = wr_addr == vltc_pkg::TRANSMIT_RETRY_ADDR;
  wire wr_stat = wr_addr == vltc_pkg::STATUS_ADDR;
  wire wr_hit = wr_line | wr_retry | wr_stat;
  wire lane0 = wr_strb[0];

  // retry register next value: version field never changes
  wire [7:0] retry_wr_val = {wr_data[7:4], version_fixed, wr_data[0]};

  // =====================================================================
  // write path registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      aw_held_q <= wr_go ? 1'b0 : have_aw;
      w_held_q <= wr_go ? 1'b0 : have_w;
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // setting registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_coding_q <= vltc_pkg::LINE_CODING_RESET;
      retry_ctl_q <= vltc_pkg::TRANSMIT_RETRY_RESET;
    end
    else if (wr_go & lane0)
    begin
      // bit 3 is reserved and always stays zero
      if (wr_line)
        line_coding_q <= {wr_data[7:4], 1'b0, wr_data[2:0]};
      if (wr_retry)
        retry_ctl_q <= retry_wr_val;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= vltc_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? vltc_pkg::RESP_OKAY : vltc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // =====================================================================
  // read path: one cycle after address
  assign s_axi_arready = ~rvalid_q;
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire rd_line = s_axi_araddr == vltc_pkg::LINE_CODING_ADDR;
  wire rd_retry = s_axi_araddr == vltc_pkg::TRANSMIT_RETRY_ADDR;
  wire rd_stat = s_axi_araddr == vltc_pkg::STATUS_ADDR;
  wire [31:0] stat_word = {16'h0000, 3'h0, attempts_q, 5'h00,
    rank_allowed, diag_enable, module_type_select};
  wire [31:0] rd_word = rd_line ? {24'h000000, line_coding_q} :
    rd_retry ? {24'h000000, retry_ctl_q} :
    rd_stat ? stat_word : 32'h0000_0000;
  wire rd_hit = rd_line | rd_retry | rd_stat;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= vltc_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? vltc_pkg::RESP_OKAY : vltc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // =====================================================================
  // access rank permission from module type
  wire rank_sync = req_rank == vltc_pkg::RANK_SYNC_ACCESS;
  wire rank_slave = req_rank == vltc_pkg::RANK_SLAVE;
  wire rank_auto = req_rank == vltc_pkg::RANK_AUTONOMOUS;
  assign rank_allowed = rank_sync | rank_slave |
    (rank_auto & module_type_select);

  // =====================================================================
  // line path and retry control
  vltc_line_path u_line (
    .pulsed_coding_select(pulsed_coding_select),
    .invert_line_output(invert_line_output),
    .invert_line_inputs(invert_line_inputs),
    .line_input_0(line_input_0),
    .line_input_1(line_input_1),
    .line_input_2(line_input_2),
    .line_output(line_output),
    .eng_tx_bit(eng_tx_bit),
    .eng_rx_bits(eng_rx_bits),
    .eng_rx_enable(eng_rx_enable),
    .diag_enable(diag_enable)
  );

  vltc_retry_ctl u_retry (
    .aclk(aclk),
    .aresetn(aresetn),
    .max_retry_count(max_retry_count),
    .tx_start(tx_start),
    .tx_ok(tx_ok),
    .tx_error(tx_error),
    .tx_contention(tx_contention),
    .tx_retry(tx_retry),
    .tx_abandon(tx_abandon),
    .attempts_q(attempts_q)
  );

  // =====================================================================
  // checks
  property p_version_fixed;
    @(posedge aclk) disable iff (!aresetn)
      version_code_field == version_fixed;
  endproperty
  a_version_fixed: assert property (p_version_fixed)
    else $error("version field changed");

  property p_pulsed_input0;
    @(posedge aclk) disable iff (!aresetn)
      pulsed_coding_select |-> eng_rx_enable == 3'h1 && !diag_enable;
  endproperty
  a_pulsed_input0: assert property (p_pulsed_input0)
    else $error("pulsed coding not on input 0 only");

  property p_manchester_all;
    @(posedge aclk) disable iff (!aresetn)
      !pulsed_coding_select |-> eng_rx_enable == 3'h7 && diag_enable;
  endproperty
  a_manchester_all: assert property (p_manchester_all)
    else $error("manchester mode lacks an input");

  property p_autonomous_ok;
    @(posedge aclk) disable iff (!aresetn)
      (module_type_select && req_rank == 5'h00) |-> rank_allowed;
  endproperty
  a_autonomous_ok: assert property (p_autonomous_ok)
    else $error("autonomous rank refused");

  property p_no_autonomous;
    @(posedge aclk) disable iff (!aresetn)
      !module_type_select |-> (rank_allowed ==
        (req_rank == 5'h01 || req_rank == 5'h10));
  endproperty
  a_no_autonomous: assert property (p_no_autonomous)
    else $error("rank permission wrong for type zero");

  property p_tx_invert;
    @(posedge aclk) disable iff (!aresetn)
      line_output == (eng_tx_bit ^ line_coding_q[1]);
  endproperty
  a_tx_invert: assert property (p_tx_invert)
    else $error("output polarity wrong");

  property p_rx_invert;
    @(posedge aclk) disable iff (!aresetn)
      eng_rx_bits == ({line_input_2, line_input_1, line_input_0} ^
        {3{invert_line_inputs}});
  endproperty
  a_rx_invert: assert property (p_rx_invert)
    else $error("input polarity wrong");

  // reserved line coding bit never set by a write
  property p_line_reserved;
    @(posedge aclk) disable iff (!aresetn)
      line_coding_q[3] == 1'b0;
  endproperty
  a_line_reserved: assert property (p_line_reserved)
    else $error("reserved line coding bit set");

  sequence s_wr_retry;
    wr_go && wr_retry && lane0;
  endsequence
  property p_retry_write;
    @(posedge aclk) disable iff (!aresetn)
      s_wr_retry |=> retry_ctl_q[7:4] == $past(wr_data[7:4]) && bvalid_q;
  endproperty
  a_retry_write: assert property (p_retry_write)
    else $error("retry count write lost");
endmodule

// file: hw/vltc_pkg.sv
// package of register offsets, field layouts and reset values
package vltc_pkg;
  // =====================================================================
  // register byte addresses (index times four)
  localparam logic [7:0] LINE_CODING_IDX = 8'h00;
  localparam logic [7:0] TRANSMIT_RETRY_IDX = 8'h01;
  localparam logic [7:0] LINE_CODING_ADDR = {LINE_CODING_IDX[5:0], 2'h0};
  localparam logic [7:0] TRANSMIT_RETRY_ADDR =
    {TRANSMIT_RETRY_IDX[5:0], 2'h0};
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  // =====================================================================
  // line coding control fields
  localparam int DIVIDER_LSB = 4;
  localparam int PULSED_BIT = 2;
  localparam int INV_OUT_BIT = 1;
  localparam int INV_IN_BIT = 0;
  localparam logic [7:0] LINE_CODING_RESET = 8'h00;
  // =====================================================================
  // transmit retry control fields
  localparam int RETRY_LSB = 4;
  localparam int VERSION_LSB = 1;
  localparam int TYPE_BIT = 0;
  localparam logic [2:0] VERSION_CODE = 3'h5; // arbitrary value
  localparam logic [7:0] TRANSMIT_RETRY_RESET = {4'h0, VERSION_CODE, 1'b0};
  // =====================================================================
  // rank codes and axi response codes
  localparam logic [4:0] RANK_AUTONOMOUS = 5'h00;
  localparam logic [4:0] RANK_SYNC_ACCESS = 5'h01;
  localparam logic [4:0] RANK_SLAVE = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/vltc_line_path.sv
// line input selection and polarity handling
`timescale 1ns/1ps
module vltc_line_path (
  // settings
  input wire logic pulsed_coding_select,
  input wire logic invert_line_output,
  input wire logic invert_line_inputs,
  // line side
  input wire logic line_input_0,
  input wire logic line_input_1,
  input wire logic line_input_2,
  output logic line_output,
  // engine side
  input wire logic eng_tx_bit,
  output logic [2:0] eng_rx_bits,
  output logic [2:0] eng_rx_enable,
  output logic diag_enable
);
  // =====================================================================
  // polarity and input selection
  wire [2:0] raw_in = {line_input_2, line_input_1, line_input_0};
  wire [2:0] inv_mask = {3{invert_line_inputs}};
  assign eng_rx_bits = raw_in ^ inv_mask;
  assign line_output = eng_tx_bit ^ invert_line_output;
  assign eng_rx_enable = pulsed_coding_select ? 3'h1 : 3'h7;
  assign diag_enable = ~pulsed_coding_select;
endmodule

// file: hw/vltc_retry_ctl.sv
// transmission attempt counter with retry limit
`timescale 1ns/1ps
module vltc_retry_ctl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire logic [3:0] max_retry_count,
  // engine events
  input wire logic tx_start,
  input wire logic tx_ok,
  input wire logic tx_error,
  input wire logic tx_contention,
  // results
  output logic tx_retry,
  output logic tx_abandon,
  output logic [4:0] attempts_q
);
  logic [4:0] attempts_d;
  // errors count, lost contention does not
  wire at_limit = attempts_q > {1'b0, max_retry_count};
  wire err_seen = tx_error & ~tx_contention;
  assign tx_retry = tx_contention | (err_seen & ~at_limit);
  assign tx_abandon = err_seen & at_limit;
  // attempt count: starts at one per new message
  always_comb
  begin
    attempts_d = attempts_q;
    if (tx_start)
      attempts_d = 5'h01;
    else if (tx_ok | tx_abandon)
      attempts_d = 5'h00;
    else if (err_seen & attempts_q != 5'h1f)
      attempts_d = attempts_q + 5'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      attempts_q <= 5'h00;
    else
      attempts_q <= attempts_d;
  end
  // abandon only after count plus one attempts
  property p_abandon_limit;
    @(posedge aclk) disable iff (!aresetn)
      tx_abandon |-> attempts_q == {1'b0, max_retry_count} + 5'h01;
  endproperty
  a_abandon_limit: assert property (p_abandon_limit)
    else $error("abandon before retry limit");
  property p_contention_retry;
    @(posedge aclk) disable iff (!aresetn)
      tx_contention |-> tx_retry && !tx_abandon;
  endproperty
  a_contention_retry: assert property (p_contention_retry)
    else $error("contention did not retry");
  property p_contention_count;
    @(posedge aclk) disable iff (!aresetn)
      (tx_contention && !tx_start) |=> attempts_q == $past(attempts_q);
  endproperty
  a_contention_count: assert property (p_contention_count)
    else $error("contention counted as error");
endmodule

// file: testbench/vltc_line_node.sv
// far-side line node model driving the three line inputs
`timescale 1ns/1ps
module vltc_line_node (
  // clock
  input wire logic aclk,
  // bench control
  input wire logic drive_en,
  input wire logic [2:0] drive_bits,
  // line pins
  input wire logic line_output,
  output logic line_input_0,
  output logic line_input_1,
  output logic line_input_2,
  // transmit level as a receiving node samples it
  output logic tx_seen_q
);
  // released lines fall to the pull-down level, not the last bit
  assign line_input_0 = drive_en ? drive_bits[0] : 1'b0;
  assign line_input_1 = drive_en ? drive_bits[1] : 1'b0;
  assign line_input_2 = drive_en ? drive_bits[2] : 1'b0;
  // sample the transmit pin once per clock
  always_ff @(posedge aclk)
  begin
    tx_seen_q <= line_output;
  end
endmodule

// file: testbench/van_line_transmit_control_test.sv
// self-checking bench for the line and transmit control bank
`timescale 1ns/1ps
module van_line_transmit_control_test;
  // =====================================================================
  // signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic l0, l1, l2, line_output, tx_seen_q, tx_retry, tx_abandon;
  logic drive_en = 1'b0, eng_tx_bit = 1'b0, rank_allowed, diag_enable;
  logic [2:0] drive_bits = 3'h0, eng_rx_bits, eng_rx_enable;
  logic [3:0] line_clock_divider;
  logic [3:0] ev = 4'h0; // start, ok, error, contention
  logic [4:0] req_rank = 5'h00;
  int bad_count = 0;
  int n_checks = 0;
  // =====================================================================
  // design and far-side node
  vltc_top vltc_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_input_0(l0), .line_input_1(l1), .line_input_2(l2),
    .line_output(line_output), .eng_tx_bit(eng_tx_bit),
    .eng_rx_bits(eng_rx_bits), .eng_rx_enable(eng_rx_enable),
    .diag_enable(diag_enable), .line_clock_divider(line_clock_divider),
    .tx_start(ev[3]), .tx_ok(ev[2]), .tx_error(ev[1]),
    .tx_contention(ev[0]), .tx_retry(tx_retry), .tx_abandon(tx_abandon),
    .req_rank(req_rank), .rank_allowed(rank_allowed));
  vltc_line_node vltc_line_node_i (.aclk(aclk), .drive_en(drive_en),
    .drive_bits(drive_bits), .line_output(line_output),
    .line_input_0(l0), .line_input_1(l1), .line_input_2(l2),
    .tx_seen_q(tx_seen_q));
  // =====================================================================
  // clock, reset and watchdog
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    tally_and_finish();
  end
  // =====================================================================
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // write one word, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (awvalid && awready) aw_done = 1'b1;
      if (wvalid && wready) w_done = 1'b1;
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask
  // read one word and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    check("rdata", rdata, ed);
    check("rresp", rresp, er);
  endtask
  // one engine event for one cycle, outputs settled on return
  task automatic step_ev(input logic [3:0] e);
    @(posedge aclk);
    ev <= e;
    #1;
  endtask
  // =====================================================================
  // scenarios
  task automatic t_reset();
    rd(vltc_pkg::LINE_CODING_ADDR, 32'h0, vltc_pkg::RESP_OKAY);
    rd(vltc_pkg::TRANSMIT_RETRY_ADDR, {24'h0, vltc_pkg::TRANSMIT_RETRY_RESET},
       vltc_pkg::RESP_OKAY);
    check("rx_enable", eng_rx_enable, 3'h7);
    check("diag", diag_enable, 1'b1);
  endtask
  task automatic t_line();
    wr(vltc_pkg::LINE_CODING_ADDR, 32'h04, 4'hf, vltc_pkg::RESP_OKAY);
    check("rx_enable", eng_rx_enable, 3'h1);
    check("diag", diag_enable, 1'b0);
    wr(vltc_pkg::LINE_CODING_ADDR, 32'ha3, 4'hf, vltc_pkg::RESP_OKAY);
    check("divider", line_clock_divider, 4'ha);
    @(posedge aclk);
    eng_tx_bit <= 1'b1;
    drive_en <= 1'b1;
    drive_bits <= 3'h5;
    @(posedge aclk);
    #1;
    check("line_output", line_output, 1'b0);
    check("rx_bits", eng_rx_bits, 3'h2);
    check("tx_seen", tx_seen_q, 1'b0);
    wr(vltc_pkg::LINE_CODING_ADDR, 32'h08, 4'hf, vltc_pkg::RESP_OKAY);
    #1;
    check("line_output", line_output, 1'b1);
    check("rx_bits", eng_rx_bits, 3'h5);
    drive_en <= 1'b0;
    wr(vltc_pkg::LINE_CODING_ADDR, 32'hff, 4'h0, vltc_pkg::RESP_OKAY);
    rd(vltc_pkg::LINE_CODING_ADDR, 32'h0, vltc_pkg::RESP_OKAY);
  endtask
  task automatic t_version();
    wr(vltc_pkg::TRANSMIT_RETRY_ADDR, 32'hff, 4'hf, vltc_pkg::RESP_OKAY);
    rd(vltc_pkg::TRANSMIT_RETRY_ADDR,
       {24'h0, 4'hf, vltc_pkg::VERSION_CODE, 1'b1},
       vltc_pkg::RESP_OKAY);
  endtask
  task automatic t_rank();
    logic [4:0] ranks [4] = '{5'h00, 5'h01, 5'h10, 5'h02};
    logic exp_ok;
    for (int mt = 0; mt < 2; mt++)
    begin
      wr(vltc_pkg::TRANSMIT_RETRY_ADDR,
         {24'h0, 4'h0, vltc_pkg::VERSION_CODE, mt[0]}, 4'hf,
         vltc_pkg::RESP_OKAY);
      foreach (ranks[i])
      begin
        @(posedge aclk);
        req_rank <= ranks[i];
        #1;
        exp_ok = (ranks[i] == 5'h01) || (ranks[i] == 5'h10) ||
          (ranks[i] == 5'h00 && mt == 1);
        check("rank", rank_allowed, exp_ok);
      end
    end
  endtask
  task automatic t_retry();
    int mrs [3] = '{0, 3, 15};
    foreach (mrs[i])
    begin
      wr(vltc_pkg::TRANSMIT_RETRY_ADDR,
         {24'h0, mrs[i][3:0], vltc_pkg::VERSION_CODE, 1'b0}, 4'hf,
         vltc_pkg::RESP_OKAY);
      step_ev(4'h8);
      for (int k = 1; k <= mrs[i] + 1; k++)
      begin
        step_ev(4'h2);
        check("retry", tx_retry, k <= mrs[i]);
        check("abandon", tx_abandon, k > mrs[i]);
      end
      step_ev(4'h4);
      step_ev(4'h0);
    end
  endtask
  task automatic t_contention();
    wr(vltc_pkg::TRANSMIT_RETRY_ADDR,
       {24'h0, 4'h0, vltc_pkg::VERSION_CODE, 1'b0}, 4'hf,
       vltc_pkg::RESP_OKAY);
    step_ev(4'h8);
    // lost contention flagged together with an error pulse
    repeat (5)
    begin
      step_ev(4'h3);
      check("retry", tx_retry, 1'b1);
      check("abandon", tx_abandon, 1'b0);
    end
    step_ev(4'h0);
    // status: one attempt, diagnosis on, rank 2 refused, type zero
    rd(vltc_pkg::STATUS_ADDR, {19'h0, 5'h01, 5'h00, 1'b0, 1'b1, 1'b0},
       vltc_pkg::RESP_OKAY);
    step_ev(4'h2);
    check("abandon", tx_abandon, 1'b1);
    step_ev(4'h0);
  endtask
  task automatic t_unmapped();
    wr(8'h0c, 32'h5a, 4'hf, vltc_pkg::RESP_SLVERR);
    rd(8'h0c, 32'h0, vltc_pkg::RESP_SLVERR);
  endtask
  // =====================================================================
  // verdict
  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_line();
    t_version();
    t_rank();
    t_retry();
    t_contention();
    t_unmapped();
    tally_and_finish();
  end
endmodule
